// >>> pkg/osv_defines.svh
// Constants for the overspeed supervisor: timing, limits, tables
`ifndef OSV_DEFINES_SVH
`define OSV_DEFINES_SVH

// Clock and supervision sample period
`define OSV_CLK_NS 4
`define OSV_TICK_NS 10000000
`define OSV_TICK_CYC (`OSV_TICK_NS / `OSV_CLK_NS)
`define OSV_TICK_MS 10

// Response deadlines and operator acknowledge window, in ms and in ticks
`define OSV_RESP_MS 100
`define OSV_RESP_TICKS (`OSV_RESP_MS / `OSV_TICK_MS)
`define OSV_OFFCHK_MS 50
`define OSV_OFFCHK_TICKS (`OSV_OFFCHK_MS / `OSV_TICK_MS)
`define OSV_ACK_MS 2500
`define OSV_ACK_TICKS (`OSV_ACK_MS / `OSV_TICK_MS)

// Previous-aspect hold time defaults per line
`define OSV_HOLD_ORANGE_MS 1800
`define OSV_HOLD_RED_MS 2500

// Brake assurance delay: default, lower and upper bounds
`define OSV_BA_DLY_MS 2800
`define OSV_BA_MIN_MS 2500
`define OSV_BA_MAX_MS 3000

// Speeds in 0.1 mph, deceleration in 0.1 mphps
`define OSV_BA_RATE 16
`define OSV_OS_MARGIN 10'h00a
`define OSV_REG_BAND 10'h01e
`define OSV_MOTION_MIN 10'h005
`define OSV_WHEEL_NOM 6'h1b

// Consecutive code cycles before a new code is accepted
`define OSV_ACCEPT_CYCLES 2'h3

// Aspect tables, index 8 in the top slice down to index 0 (slowest)
`define OSV_NOM_TBL {10'h258, 10'h226, 10'h1f4, 10'h190, 10'h0fa, 10'h0b4, 10'h096, 10'h064, 10'h032}
`define OSV_EOS_TBL {10'h276, 10'h244, 10'h212, 10'h1a4, 10'h118, 10'h0d2, 10'h0b4, 10'h082, 10'h046}

`endif

// >>> pkg/osv_pkg.sv
// Types shared by the overspeed supervisor modules
package osv_pkg;

  typedef logic [3:0] osv_aspect_t;

  typedef struct packed {
    logic overspeed;
    logic emerg_overspeed;
    logic ba_fail;
    logic shutdown;
    logic motion;
  } osv_status_t;

  typedef enum logic [3:0] {
    OSV_IDLE = 4'h1,
    OSV_ALARM = 4'h2,
    OSV_ACKED = 4'h4,
    OSV_STOP = 4'h8
  } osv_brake_st_t;

endpackage : osv_pkg

// >>> src/osv_tick.sv
// Sample-period divider: one-cycle enable every CYC clocks
`timescale 1ns/1ns
module osv_tick #(
  parameter int CYC = 2500000
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  output logic tick_out
);

  logic [31:0] cnt_r;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= 32'h0;
      tick_out <= 1'b0;
    end else if (cnt_r >= 32'(CYC - 1)) begin
      cnt_r <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick_out <= 1'b0;
    end
  end

endmodule : osv_tick

// >>> src/osv_aspect_filter.sv
// Cab-signal code recognition: most restrictive code, accepted after repeated cycles
`timescale 1ns/1ns
`include "osv_defines.svh"
module osv_aspect_filter #(
  parameter int NCODES = 9
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic code_cycle_in,
  input wire logic [NCODES-1:0] code_valid_in,
  output osv_pkg::osv_aspect_t aspect_out,
  output logic new_out
);

  osv_pkg::osv_aspect_t cand;
  osv_pkg::osv_aspect_t last_r;
  logic [1:0] cnt_r;

  // Lowest index is the slowest aspect
  always_comb begin
    cand = osv_pkg::osv_aspect_t'(0);
    for (int i = NCODES - 1; i >= 0; i--) begin
      if (code_valid_in[i]) begin
        cand = osv_pkg::osv_aspect_t'(i);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      last_r <= '0;
      cnt_r <= 2'h0;
    end else if (code_cycle_in) begin
      if (code_valid_in == '0) begin
        cnt_r <= 2'h0;
      end else if (cand != last_r || cnt_r == 2'h0) begin
        last_r <= cand;
        cnt_r <= 2'h1;
      end else if (cnt_r != `OSV_ACCEPT_CYCLES) begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aspect_out <= '0;
      new_out <= 1'b0;
    end else begin
      new_out <= 1'b0;
      if (cnt_r == `OSV_ACCEPT_CYCLES && last_r != aspect_out) begin
        aspect_out <= last_r;
        new_out <= 1'b1;
      end
    end
  end

endmodule : osv_aspect_filter

// >>> src/osv_supervisor.sv
// Overspeed supervisor: limits, braking, emergency trainline, output checks, regulator
// Notes on behaviour
// - Flag overspeed, then request service brake promptly
// - Emergency overspeed drops emergency trainline promptly
// - System failure removes emergency trainline drive
// - Assurance timeout or empty bank drops trainline
// - New code accepted after three code cycles
// - Previous aspect held for programmable time
// - Overspeed limit is nominal plus 1 mph
// - Emergency limits follow the fixed table
// - Upgrade applies new emergency limit at once
// - Downgrade keeps old emergency limit until underspeed
// - Brake assurance rate parameter, default 1.6
// - Assurance delay 2.8 s, adjustable 2.5-3
// - Stuck-on output shuts all three vital outputs down
// - Motion reported from 0.5 mph upward
// - Wheel diameter writable only with key
// - Simultaneous codes enforce most restrictive aspect
// - Regulator caps speed at nominal, 3 below
// - Unacknowledged overspeed brakes to a full stop
// - No emergency drop when already decelerating enough
`timescale 1ns/1ns
`include "osv_defines.svh"
module osv_supervisor #(
  parameter int SAMPLE_CYC = `OSV_TICK_CYC,
  parameter bit RED_LINE = 1'b0,
  parameter logic [7:0] BA_RATE = 8'(`OSV_BA_RATE),
  parameter int NCODES = 9
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic code_cycle_in,
  input wire logic [NCODES-1:0] code_valid_in,
  input wire logic [9:0] speed_raw_in,
  input wire logic [7:0] decel_in,
  input wire logic ack_full_service_in,
  input wire logic reg_mode_in,
  input wire logic full_power_in,
  input wire logic sys_fail_in,
  input wire logic bank_empty_in,
  input wire logic [2:0] out_fb_in,
  input wire logic key_ok_in,
  input wire logic wheel_wr_in,
  input wire logic [5:0] wheel_dia_in,
  input wire logic hold_wr_in,
  input wire logic [11:0] hold_ms_in,
  input wire logic ba_wr_in,
  input wire logic [11:0] ba_ms_in,
  output logic emerg_ok_out,
  output logic brake_apply_n_out,
  output logic traction_en_out,
  output osv_pkg::osv_aspect_t aspect_out,
  output osv_pkg::osv_status_t status_out
);

  function automatic logic [9:0] nom_of(input osv_pkg::osv_aspect_t idx);
    logic [10*NCODES-1:0] tbl;
    tbl = `OSV_NOM_TBL;
    nom_of = tbl[idx*10 +: 10];
  endfunction : nom_of

  function automatic logic [9:0] eos_of(input osv_pkg::osv_aspect_t idx);
    logic [10*NCODES-1:0] tbl;
    tbl = `OSV_EOS_TBL;
    eos_of = tbl[idx*10 +: 10];
  endfunction : eos_of

  function automatic logic [8:0] ms_to_ticks(input logic [11:0] ms);
    ms_to_ticks = 9'(ms / 12'(`OSV_TICK_MS));
  endfunction : ms_to_ticks

  logic tick;
  logic new_asp;
  osv_pkg::osv_aspect_t act_idx;
  osv_pkg::osv_aspect_t enf_idx_r;
  osv_pkg::osv_aspect_t eos_idx_r;
  osv_pkg::osv_brake_st_t st_r;
  osv_pkg::osv_brake_st_t st_nxt;
  logic [5:0] dia_r;
  logic [9:0] spd_r;
  logic [8:0] hold_ticks_r;
  logic [8:0] hold_cnt_r;
  logic [8:0] ba_ticks_r;
  logic [8:0] ba_cnt_r;
  logic [8:0] ack_cnt_r;
  logic [3:0] off_cnt_r;
  logic ovs_r;
  logic eos_r;
  logic ba_fail_r;
  logic shut_r;
  logic emerg_lat_r;
  logic reg_on_r;
  logic [9:0] os_lim;
  logic [9:0] new_os_lim;
  logic [9:0] eos_lim;
  logic [9:0] nom_spd;
  logic decel_ok;
  logic drop_now;
  logic [2:0] stuck;
  logic [11:0] ba_ms_clip;
  logic [15:0] spd_prod;

  osv_tick #(
    .CYC(SAMPLE_CYC)
  ) u_tick (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .tick_out(tick)
  );

  osv_aspect_filter #(
    .NCODES(NCODES)
  ) u_filter (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .code_cycle_in(code_cycle_in),
    .code_valid_in(code_valid_in),
    .aspect_out(act_idx),
    .new_out(new_asp)
  );

  assign nom_spd = nom_of(enf_idx_r);
  assign os_lim = nom_spd + `OSV_OS_MARGIN;
  assign new_os_lim = nom_of(act_idx) + `OSV_OS_MARGIN;
  assign eos_lim = eos_of(eos_idx_r);
  assign decel_ok = decel_in >= BA_RATE;
  assign spd_prod = speed_raw_in * dia_r;
  assign ba_ms_clip = (ba_ms_in < 12'(`OSV_BA_MIN_MS)) ? 12'(`OSV_BA_MIN_MS) :
                      (ba_ms_in > 12'(`OSV_BA_MAX_MS)) ? 12'(`OSV_BA_MAX_MS) : ba_ms_in;
  assign stuck = out_fb_in & ~{traction_en_out, brake_apply_n_out, emerg_ok_out};
  assign drop_now = (eos_r && !decel_ok) || ba_fail_r || bank_empty_in || sys_fail_in || shut_r;

  // Settings, guarded wheel diameter
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dia_r <= `OSV_WHEEL_NOM;
      hold_ticks_r <= RED_LINE ? 9'(`OSV_HOLD_RED_MS / `OSV_TICK_MS) : 9'(`OSV_HOLD_ORANGE_MS / `OSV_TICK_MS);
      ba_ticks_r <= 9'(`OSV_BA_DLY_MS / `OSV_TICK_MS);
    end else begin
      if (wheel_wr_in && key_ok_in) begin
        dia_r <= wheel_dia_in;
      end
      if (hold_wr_in) begin
        hold_ticks_r <= ms_to_ticks(hold_ms_in);
      end
      if (ba_wr_in) begin
        ba_ticks_r <= ms_to_ticks(ba_ms_clip);
      end
    end
  end

  // Speed scaled from the nominal wheel to the set wheel
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      spd_r <= 10'h000;
    end else begin
      spd_r <= 10'(spd_prod / 16'(`OSV_WHEEL_NOM));
    end
  end

  // Aspect enforced for overspeed, after the hold time
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enf_idx_r <= '0;
      hold_cnt_r <= 9'h000;
    end else if (new_asp) begin
      hold_cnt_r <= hold_ticks_r;
    end else if (hold_cnt_r != 9'h000) begin
      if (tick) begin
        hold_cnt_r <= hold_cnt_r - 9'h001;
      end
    end else begin
      enf_idx_r <= act_idx;
    end
  end

  // Emergency limit aspect: upgrades at once, downgrades once underspeed
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      eos_idx_r <= '0;
    end else if (act_idx >= eos_idx_r) begin
      eos_idx_r <= act_idx;
    end else if (spd_r < new_os_lim) begin
      eos_idx_r <= act_idx;
    end
  end

  // Sampled limit comparison
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ovs_r <= 1'b0;
      eos_r <= 1'b0;
    end else if (tick) begin
      ovs_r <= spd_r > os_lim;
      eos_r <= spd_r > eos_lim;
    end
  end

  // Service brake sequence after an overspeed
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      osv_pkg::OSV_IDLE: begin
        if (ovs_r) begin
          st_nxt = osv_pkg::OSV_ALARM;
        end
      end
      osv_pkg::OSV_ALARM: begin
        if (ack_full_service_in) begin
          st_nxt = osv_pkg::OSV_ACKED;
        end else if (ack_cnt_r >= 9'(`OSV_ACK_TICKS)) begin
          st_nxt = osv_pkg::OSV_STOP;
        end
      end
      osv_pkg::OSV_ACKED: begin
        if (!ovs_r) begin
          st_nxt = osv_pkg::OSV_IDLE;
        end
      end
      osv_pkg::OSV_STOP: begin
        if (spd_r == 10'h000 && !ovs_r) begin
          st_nxt = osv_pkg::OSV_IDLE;
        end
      end
      default: begin
        st_nxt = osv_pkg::OSV_STOP;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= osv_pkg::OSV_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_cnt_r <= 9'h000;
    end else if (st_r != osv_pkg::OSV_ALARM) begin
      ack_cnt_r <= 9'h000;
    end else if (tick) begin
      ack_cnt_r <= ack_cnt_r + 9'h001;
    end
  end

  // Brake assurance timer, running from overspeed detection
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ba_cnt_r <= 9'h000;
      ba_fail_r <= 1'b0;
    end else if (st_r == osv_pkg::OSV_IDLE) begin
      ba_cnt_r <= 9'h000;
      ba_fail_r <= 1'b0;
    end else if (tick && !decel_ok) begin
      if (ba_cnt_r >= ba_ticks_r) begin
        ba_fail_r <= 1'b1;
      end else begin
        ba_cnt_r <= ba_cnt_r + 9'h001;
      end
    end
  end

  // Outputs that stay energised after being commanded off
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      off_cnt_r <= 4'h0;
      shut_r <= 1'b0;
    end else if (tick) begin
      if (stuck == 3'h0) begin
        off_cnt_r <= 4'h0;
      end else if (off_cnt_r >= 4'(`OSV_OFFCHK_TICKS - 1)) begin
        shut_r <= 1'b1;
      end else begin
        off_cnt_r <= off_cnt_r + 4'h1;
      end
    end
  end

  // Emergency trainline drop, latched until standstill
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      emerg_lat_r <= 1'b0;
    end else if (drop_now) begin
      emerg_lat_r <= 1'b1;
    end else if (spd_r == 10'h000) begin
      emerg_lat_r <= 1'b0;
    end
  end

  // Regulator hysteresis under the nominal speed
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_on_r <= 1'b0;
    end else if (spd_r >= nom_spd) begin
      reg_on_r <= 1'b0;
    end else if (spd_r + `OSV_REG_BAND <= nom_spd) begin
      reg_on_r <= 1'b1;
    end
  end

  // Registered outputs; low is the safe state of every vital output
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      emerg_ok_out <= 1'b0;
      brake_apply_n_out <= 1'b0;
      traction_en_out <= 1'b0;
    end else if (shut_r) begin
      emerg_ok_out <= 1'b0;
      brake_apply_n_out <= 1'b0;
      traction_en_out <= 1'b0;
    end else begin
      emerg_ok_out <= !(drop_now || emerg_lat_r);
      brake_apply_n_out <= !(ovs_r || st_r != osv_pkg::OSV_IDLE);
      traction_en_out <= full_power_in && !ovs_r && st_r == osv_pkg::OSV_IDLE && !emerg_lat_r &&
                         (!reg_mode_in || reg_on_r);
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aspect_out <= '0;
      status_out <= '0;
    end else begin
      aspect_out <= enf_idx_r;
      status_out.overspeed <= ovs_r;
      status_out.emerg_overspeed <= eos_r;
      status_out.ba_fail <= ba_fail_r;
      status_out.shutdown <= shut_r;
      status_out.motion <= spd_r >= `OSV_MOTION_MIN;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  a_os_flag: assert property (tick && spd_r > os_lim |=> ovs_r)
    else $error("overspeed not flagged on sample");
  a_os_brake: assert property ($rose(ovs_r) && !shut_r |=> !brake_apply_n_out)
    else $error("brake not requested after overspeed");
  a_eos_drop: assert property (eos_r && !decel_ok |=> !emerg_ok_out)
    else $error("emergency trainline kept on emergency overspeed");
  a_fail_drop: assert property (sys_fail_in |-> ##1 !emerg_ok_out ##1 !emerg_ok_out)
    else $error("emergency trainline kept on system failure");
  a_bank_drop: assert property (bank_empty_in || ba_fail_r |=> !emerg_ok_out)
    else $error("emergency trainline kept on assurance loss");
  a_shut_all: assert property ($rose(shut_r) |=> !emerg_ok_out && !brake_apply_n_out && !traction_en_out)
    else $error("outputs still on after shutdown");
  a_motion_rpt: assert property (spd_r >= `OSV_MOTION_MIN |=> status_out.motion)
    else $error("motion not reported");
  a_wheel_lock: assert property (!key_ok_in |=> $stable(dia_r))
    else $error("wheel diameter changed without key");
  a_reg_cap: assert property (reg_mode_in && spd_r >= nom_spd |=> ##1 !traction_en_out)
    else $error("regulator powers at or above nominal speed");
  a_eos_hold: assert property (act_idx < eos_idx_r && spd_r >= new_os_lim |=> $stable(eos_idx_r))
    else $error("emergency limit lowered while overspeed");
  a_eos_up: assert property (act_idx > eos_idx_r |=> eos_idx_r == $past(act_idx))
    else $error("upgrade emergency limit delayed");

  c_overspeed: cover property ($rose(ovs_r));
  c_acked: cover property (st_r == osv_pkg::OSV_ACKED);
  c_stop: cover property (st_r == osv_pkg::OSV_STOP);
  c_shutdown: cover property ($rose(shut_r));

endmodule : osv_supervisor

// >>> testbench/osv_partner.sv
// Far-side model: cab code source and output readback with a stuck-contact fault
`timescale 1ns/1ns
module osv_partner #(
  parameter int CODE_CYC = 40
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [8:0] code_in,
  input wire logic stuck_in,
  input wire logic [2:0] outs_in,
  output logic code_cycle_out,
  output logic [8:0] code_valid_out,
  output logic [2:0] out_fb_out
);
  int cnt_r;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= 0;
      code_cycle_out <= 1'b0;
      code_valid_out <= 9'h000;
    end else begin
      cnt_r <= (cnt_r == CODE_CYC - 1) ? 0 : cnt_r + 1;
      code_cycle_out <= (cnt_r == CODE_CYC - 1);
      code_valid_out <= code_in;
    end
  end
  // Readback follows the outputs; a welded contact keeps the brake line energised
  assign out_fb_out = outs_in | {1'b0, stuck_in, 1'b0};
endmodule : osv_partner

// >>> testbench/tb_top.sv
// Self-checking bench for the overspeed supervisor
`timescale 1ns/1ns
module tb_top;
  localparam int TCK = 10;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic code_cycle, stuck, ack, reg_mode, full_power, sys_fail, bank_empty, key_ok, wheel_wr, hold_wr, ba_wr;
  logic [8:0] code, code_valid;
  logic [9:0] speed;
  logic [7:0] decel, lfsr;
  logic [5:0] wheel_dia;
  logic [11:0] hold_ms, ba_ms;
  logic [2:0] out_fb;
  logic emerg_ok, brake_n, traction;
  osv_pkg::osv_aspect_t aspect;
  osv_pkg::osv_status_t stat;
  int nom[9] = '{50, 100, 150, 180, 250, 400, 500, 550, 600};
  int eos[9] = '{70, 130, 180, 210, 280, 420, 530, 580, 630};
  string nm[9] = '{"overspeed", "emerg_ok", "brake_apply_n", "traction", "shutdown", "motion", "aspect",
                   "emerg_overspeed", "ba_fail"};
  int bad_count, compares, cyc, tgt;

  always #2 clk_sys_in = ~clk_sys_in;

  osv_supervisor #(.SAMPLE_CYC(TCK)) i_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .code_cycle_in(code_cycle), .code_valid_in(code_valid), .speed_raw_in(speed), .decel_in(decel),
    .ack_full_service_in(ack), .reg_mode_in(reg_mode), .full_power_in(full_power), .sys_fail_in(sys_fail),
    .bank_empty_in(bank_empty), .out_fb_in(out_fb), .key_ok_in(key_ok), .wheel_wr_in(wheel_wr),
    .wheel_dia_in(wheel_dia), .hold_wr_in(hold_wr), .hold_ms_in(hold_ms), .ba_wr_in(ba_wr), .ba_ms_in(ba_ms),
    .emerg_ok_out(emerg_ok), .brake_apply_n_out(brake_n), .traction_en_out(traction), .aspect_out(aspect),
    .status_out(stat));

  osv_partner i_far (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .code_in(code), .stuck_in(stuck),
    .outs_in({traction, brake_n, emerg_ok}), .code_cycle_out(code_cycle), .code_valid_out(code_valid),
    .out_fb_out(out_fb));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  function automatic logic sig(input int s);
    case (s)
      0: return stat.overspeed;
      1: return emerg_ok;
      2: return brake_n;
      3: return traction;
      4: return stat.shutdown;
      5: return stat.motion;
      6: return (aspect === 4'(tgt));
      7: return stat.emerg_overspeed;
      default: return stat.ba_fail;
    endcase
  endfunction : sig

  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string name);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // Waits up to the given number of sample ticks for a settled value
  task automatic wait_sig(input int s, input logic v, input int ticks);
    int n;
    n = 0;
    while (sig(s) !== v && n < ticks * TCK) begin
      @(negedge clk_sys_in);
      n++;
    end
    #1 check(10'(sig(s)), 10'(v), nm[s]);
  endtask : wait_sig

  // Value must not leave v during the given number of ticks
  task automatic hold_sig(input int s, input logic v, input int ticks);
    logic seen;
    seen = v;
    repeat (ticks * TCK) begin
      @(posedge clk_sys_in);
      #1 if (sig(s) !== v) seen = sig(s);
    end
    check(10'(seen), 10'(v), nm[s]);
  endtask : hold_sig

  task automatic spd(input int v);
    @(posedge clk_sys_in);
    speed <= 10'(v);
  endtask : spd

  task automatic strobe(input int w);
    @(posedge clk_sys_in);
    {wheel_wr, hold_wr, ba_wr} <= 3'(4 >> w);
    @(posedge clk_sys_in);
    {wheel_wr, hold_wr, ba_wr} <= 3'h0;
  endtask : strobe

  task automatic to_stop();
    spd(0);
    decel <= 8'h00;
    wait_sig(1, 1'b1, 30);
    // Without acknowledge the brake stays on until the acknowledge window has run out
    wait_sig(2, 1'b1, 260);
  endtask : to_stop

  task automatic complete_run();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 100000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    {stuck, ack, reg_mode, full_power, sys_fail, bank_empty, key_ok} = 7'h00;
    {wheel_wr, hold_wr, ba_wr} = 3'h0;
    code = 9'h000;
    speed = 10'h000;
    decel = 8'h00;
    lfsr = 8'h57;
    wheel_dia = 6'h1b;
    hold_ms = 12'h064;
    ba_ms = 12'h3e8;
    repeat (2) @(posedge clk_sys_in);
    #1 check(10'({emerg_ok, brake_n, traction}), 10'h000, "reset outputs");
    reset_n_in <= 1'b1;
    wait_sig(1, 1'b1, 2);
    wait_sig(2, 1'b1, 2);
    // Two codes at once, default hold keeps the old aspect first
    code <= 9'h104;
    tgt = 2;
    hold_sig(6, 1'b0, 170);
    wait_sig(6, 1'b1, 30);
    strobe(1);
    for (int a = 0; a < 9; a++) begin
      code <= 9'(1 << a);
      tgt = a;
      wait_sig(6, 1'b1, 30);
      spd(nom[a] + 10);
      hold_sig(0, 1'b0, 15);
      lfsr = lfsr_next(lfsr);
      decel <= {4'h0, lfsr[3:0]};
      spd(nom[a] + 11);
      wait_sig(0, 1'b1, 10);
      wait_sig(2, 1'b0, 10);
      spd(eos[a]);
      hold_sig(1, 1'b1, 10);
      spd(eos[a] + 1);
      wait_sig(1, 1'b0, 20);
      wait_sig(7, 1'b1, 1);
      to_stop();
    end
    // Braking already strong enough: trainline stays up
    decel <= 8'h14;
    spd(640);
    hold_sig(1, 1'b1, 20);
    to_stop();
    // Downgrade keeps the old emergency limit until underspeed
    spd(600);
    code <= 9'h080;
    tgt = 7;
    wait_sig(6, 1'b1, 30);
    hold_sig(1, 1'b1, 20);
    spd(555);
    repeat (3 * TCK) @(posedge clk_sys_in);
    spd(590);
    wait_sig(1, 1'b0, 20);
    to_stop();
    // Assurance delay written below range is clamped to 2.5 s
    strobe(2);
    spd(561);
    hold_sig(1, 1'b1, 240);
    wait_sig(1, 1'b0, 25);
    wait_sig(8, 1'b1, 1);
    to_stop();
    sys_fail <= 1'b1;
    wait_sig(1, 1'b0, 20);
    sys_fail <= 1'b0;
    wait_sig(1, 1'b1, 20);
    bank_empty <= 1'b1;
    wait_sig(1, 1'b0, 10);
    bank_empty <= 1'b0;
    wait_sig(1, 1'b1, 20);
    // Unacknowledged overspeed brakes to a stop; acknowledged releases underspeed
    spd(561);
    wait_sig(2, 1'b0, 20);
    spd(500);
    hold_sig(2, 1'b0, 20);
    to_stop();
    ack <= 1'b1;
    spd(561);
    wait_sig(2, 1'b0, 20);
    spd(500);
    wait_sig(2, 1'b1, 20);
    ack <= 1'b0;
    // Regulator band below nominal
    reg_mode <= 1'b1;
    full_power <= 1'b1;
    wait_sig(3, 1'b1, 10);
    spd(550);
    wait_sig(3, 1'b0, 10);
    spd(521);
    hold_sig(3, 1'b0, 10);
    spd(520);
    wait_sig(3, 1'b1, 10);
    reg_mode <= 1'b0;
    spd(5);
    wait_sig(5, 1'b1, 10);
    // Wheel setting needs the key
    wheel_dia <= 6'h36;
    strobe(0);
    spd(281);
    hold_sig(0, 1'b0, 10);
    key_ok <= 1'b1;
    strobe(0);
    wait_sig(0, 1'b1, 10);
    wheel_dia <= 6'h1b;
    strobe(0);
    key_ok <= 1'b0;
    to_stop();
    // Brake readback stuck on while commanded off
    stuck <= 1'b1;
    spd(561);
    wait_sig(4, 1'b1, 25);
    wait_sig(1, 1'b0, 10);
    wait_sig(3, 1'b0, 10);
    stuck <= 1'b0;
    spd(0);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    wait_sig(4, 1'b0, 1);
    wait_sig(1, 1'b1, 2);
    tgt = 0;
    wait_sig(6, 1'b1, 1);
    complete_run();
  end
endmodule : tb_top
